// file: src/dao_door_ctrl.sv
/*
  door alarm output and option logic for one door: three pulsable
  indicator outputs, lock control, schedule handling and event strobes.
  assumes sensor and request pins are asynchronous and that schedule and
  area inputs come from same-clock logic.
*/
`timescale 1ns/100ps
module dao_door_ctrl (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic door_open_i,            // door contact, pin
  input wire logic request_to_exit_i,      // pin
  input wire logic request_to_enter_i,     // pin
  input wire logic access_granted_i,       // one-cycle pulse, same clock
  input wire logic sched_valid_i,          // schedule window level
  input wire logic minute_tick_i,          // one-cycle pulse each minute
  input wire logic inside_disarmed_i,      // follow-inside request
  input wire logic outside_disarmed_i,     // follow-outside request
  input wire logic [7:0] options_i,        // miscellaneous options
  input wire logic [7:0] pre_alarm_sec_i,
  input wire logic [7:0] max_open_sec_i,
  input wire logic [7:0] unlock_sec_i,     // access unlock time
  input wire dao_pkg::dao_pulse_cfg_t pre_cfg_i,
  input wire dao_pkg::dao_pulse_cfg_t left_cfg_i,
  input wire dao_pkg::dao_pulse_cfg_t forced_cfg_i,
  output logic pre_alarm_o,
  output logic left_open_o,
  output logic forced_o,
  output logic lock_o,                     // high = lock released
  output dao_pkg::dao_events_t events_o
);

  // ==========================================================
  // input synchronisers
  // ==========================================================
  logic [2:0] sync1_q; // first stage, read only by second stage
  logic [2:0] sync2_q;
  logic door_prev_q; // for edge detect
  logic door, request_to_exit, ren;

  // two flops on every pin
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      door_prev_q <= 1'b0;
    end else begin
      sync1_q <= {request_to_enter_i, request_to_exit_i, door_open_i};
      sync2_q <= sync1_q;
      door_prev_q <= sync2_q[0];
    end
  end
  assign door = sync2_q[0];
  assign request_to_exit = sync2_q[1];
  assign ren = sync2_q[2];

  logic door_rise, door_fall;
  assign door_rise = door & ~door_prev_q;
  assign door_fall = ~door & door_prev_q;

  // ==========================================================
  // 100 ms tick and second tick
  // ==========================================================
  logic [19:0] div_q;
  logic tick_q; // one-cycle enable
  logic [3:0] sec_div_q;
  logic sec_tick;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      div_q <= 20'h00000;
      tick_q <= 1'b0;
    end else if (div_q == 20'(dao_pkg::TICK_CYCLES - 1)) begin
      div_q <= 20'h00000;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 20'h00001;
      tick_q <= 1'b0;
    end
  end

  // seconds derived from ticks
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      sec_div_q <= 4'h0;
    end else if (tick_q) begin
      if (sec_div_q == dao_pkg::TICKS_PER_SEC - 4'h1) begin
        sec_div_q <= 4'h0;
      end else begin
        sec_div_q <= sec_div_q + 4'h1;
      end
    end
  end
  assign sec_tick = tick_q && (sec_div_q == dao_pkg::TICKS_PER_SEC - 4'h1);

  // ==========================================================
  // open time counter
  // ==========================================================
  logic [7:0] open_sec_q; // saturating seconds since opening
  logic pre_act_q, left_act_q, forced_act_q;
  logic authorised_q; // access or request since door closed
  logic pre_hit, left_hit;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i || !door || door_rise) begin
      open_sec_q <= 8'h00;
    end else if (sec_tick && open_sec_q != 8'hFF) begin
      open_sec_q <= open_sec_q + 8'h01;
    end
  end

  assign pre_hit = door && !pre_act_q && (pre_alarm_sec_i != 8'h00) &&
                   (open_sec_q >= pre_alarm_sec_i);
  assign left_hit = door && !left_act_q && (open_sec_q >= max_open_sec_i)
                    && !door_rise;

  // ==========================================================
  // alarm activations
  // ==========================================================
  // activate, clear on close
  always_ff @(posedge clock_i) begin
    if (!reset_n_i || !door) begin
      pre_act_q <= 1'b0;
      left_act_q <= 1'b0;
    end else begin
      if (pre_hit) begin
        pre_act_q <= 1'b1;
      end
      if (left_hit) begin
        left_act_q <= 1'b1;
      end
    end
  end

  // authorised while lock released or access seen; cleared at close
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      authorised_q <= 1'b0;
    end else if (access_granted_i || lock_o || request_to_exit || ren) begin
      authorised_q <= 1'b1; // set wins over close
    end else if (door_fall) begin
      authorised_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i || !door) begin
      forced_act_q <= 1'b0;
    end else if (door_rise && !authorised_q && !access_granted_i &&
                 !lock_o && !request_to_exit && !ren) begin
      forced_act_q <= 1'b1;
    end
  end

  // ==========================================================
  // pulse generators, one per output
  // ==========================================================
  logic [2:0] act;
  dao_pkg::dao_pulse_cfg_t cfg [3];
  logic [2:0] out_q;
  logic [7:0] ph_cnt_q [3]; // steps left in current phase
  logic [2:0] ph_on_q;      // current phase is on

  assign act = {forced_act_q, left_act_q, pre_act_q};
  assign cfg[0] = pre_cfg_i;   // pre-alarm times
  assign cfg[1] = left_cfg_i;  // left-open times
  assign cfg[2] = forced_cfg_i; // forced times

  // both times nonzero enable pulsing
  function automatic logic pulsing(input dao_pkg::dao_pulse_cfg_t c);
    pulsing = (c.on_time != 8'h00) && (c.off_time != 8'h00);
  endfunction : pulsing

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_pulse
      always_ff @(posedge clock_i) begin
        if (!reset_n_i || !act[g]) begin
          ph_on_q[g] <= 1'b1;
          ph_cnt_q[g] <= 8'h00;
          out_q[g] <= 1'b0;
        end else if (!pulsing(cfg[g])) begin
          out_q[g] <= 1'b1; // steady while active
          ph_on_q[g] <= 1'b1;
          ph_cnt_q[g] <= 8'h00;
        end else if (!out_q[g] && ph_on_q[g] && ph_cnt_q[g] == 8'h00) begin
          // first cycle of activation: load on-phase
          out_q[g] <= 1'b1;
          ph_cnt_q[g] <= cfg[g].on_time;
        end else if (tick_q) begin
          if (ph_cnt_q[g] <= 8'h01) begin
            ph_on_q[g] <= ~ph_on_q[g];
            out_q[g] <= ~ph_on_q[g];
            ph_cnt_q[g] <= ph_on_q[g] ? cfg[g].off_time : cfg[g].on_time;
          end else begin
            ph_cnt_q[g] <= ph_cnt_q[g] - 8'h01;
          end
        end
      end
    end
  endgenerate
  assign pre_alarm_o = out_q[0];
  assign left_open_o = out_q[1];
  assign forced_o = out_q[2];

  // ==========================================================
  // schedule handling
  // ==========================================================
  logic sched_prev_q;
  logic sched_unlock_q; // schedule currently holding lock open
  logic late_ok_q;      // first access seen in this window
  logic sched_eval;
  logic area_follow;

  // evaluate each minute or at edges
  assign sched_eval = (sched_valid_i != sched_prev_q) ||
                      (options_i[dao_pkg::OPT_REVAL] && minute_tick_i);
  assign area_follow = !options_i[dao_pkg::OPT_REVAL] &&
                       (inside_disarmed_i || outside_disarmed_i);

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      late_ok_q <= 1'b0;
    end else if (access_granted_i && sched_valid_i) begin
      late_ok_q <= 1'b1; // set wins
    end else if (!sched_valid_i) begin
      late_ok_q <= 1'b0;
    end
  end

  // schedule sampled on evaluation, or on access while late open is set
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      sched_prev_q <= 1'b0;
      sched_unlock_q <= 1'b0;
    end else begin
      sched_prev_q <= sched_valid_i;
      if (sched_eval) begin
        sched_unlock_q <= sched_valid_i &&
          (!options_i[dao_pkg::OPT_LATE_OPEN] || late_ok_q ||
           access_granted_i);
      end else if (options_i[dao_pkg::OPT_LATE_OPEN] && sched_valid_i &&
                   access_granted_i) begin
        sched_unlock_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // lock control
  // ==========================================================
  logic [7:0] unlock_cnt_q; // seconds of timed unlock left
  logic timed_q;
  logic rex_req, ren_req;

  assign rex_req = request_to_exit && options_i[dao_pkg::OPT_REX_UNLOCK];
  assign ren_req = ren && options_i[dao_pkg::OPT_REN_UNLOCK];

  // timed unlock; zero unlock time means no release
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      timed_q <= 1'b0;
      unlock_cnt_q <= 8'h00;
    end else if ((access_granted_i || rex_req || ren_req) &&
                 unlock_sec_i != 8'h00) begin
      timed_q <= 1'b1;
      unlock_cnt_q <= unlock_sec_i;
    end else if (door_fall && options_i[dao_pkg::OPT_RELOCK] && timed_q) begin
      timed_q <= 1'b0;
      unlock_cnt_q <= 8'h00;
    end else if (sec_tick && timed_q) begin
      if (unlock_cnt_q <= 8'h01) begin
        timed_q <= 1'b0;
        unlock_cnt_q <= 8'h00;
      end else begin
        unlock_cnt_q <= unlock_cnt_q - 8'h01;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      lock_o <= 1'b0;
    end else begin
      lock_o <= timed_q || sched_unlock_q || area_follow;
    end
  end

  // ==========================================================
  // events
  // ==========================================================
  // event strobes
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      events_o <= '0;
    end else begin
      events_o.opened <= door_rise && !(sched_unlock_q &&
                         options_i[dao_pkg::OPT_NO_SCHED_EVT]);
      events_o.closed <= door_fall && !(sched_unlock_q &&
                         options_i[dao_pkg::OPT_NO_SCHED_EVT]);
      events_o.pre_alarm <= pre_hit && options_i[dao_pkg::OPT_PRE_EVT];
      events_o.left_open <= left_hit && options_i[dao_pkg::OPT_LEFT_EVT];
      events_o.forced <= door_rise && !authorised_q && !access_granted_i &&
                         !lock_o && !request_to_exit && !ren;
    end
  end

  // ==========================================================
  // assertions
  // ==========================================================
  sequence s_close;
    $fell(door);
  endsequence

  AST_CLOSE_CLEARS: assert property (@(posedge clock_i)
    disable iff (!reset_n_i) s_close |=> ##1 (!pre_alarm_o && !left_open_o))
    else $error("alarm output stayed on after close");

  AST_PRE_ZERO_OFF: assert property (@(posedge clock_i)
    disable iff (!reset_n_i) (pre_alarm_sec_i == 8'h00) |-> !pre_act_q)
    else $error("pre-alarm active with zero time");

  AST_STEADY: assert property (@(posedge clock_i)
    disable iff (!reset_n_i)
    (left_act_q && !pulsing(left_cfg_i) && $stable(left_cfg_i))
    |=> (left_open_o || !left_act_q))
    else $error("steady output dropped");

  AST_ON_FIRST: assert property (@(posedge clock_i)
    disable iff (!reset_n_i) $rose(forced_act_q) |=> forced_o)
    else $error("activation did not start on");

  AST_PRE_EVT_GATE: assert property (@(posedge clock_i)
    disable iff (!reset_n_i)
    $rose(events_o.pre_alarm) |-> $past(options_i[dao_pkg::OPT_PRE_EVT]))
    else $error("pre-alarm event logged while disabled");

  AST_LEFT_EVT_GATE: assert property (@(posedge clock_i)
    disable iff (!reset_n_i)
    (left_hit && options_i[dao_pkg::OPT_LEFT_EVT]) |=> events_o.left_open)
    else $error("left-open event missing");

  AST_REX_UNLOCK: assert property (@(posedge clock_i)
    disable iff (!reset_n_i)
    (rex_req && unlock_sec_i != 8'h00) |=> ##1 lock_o)
    else $error("request to exit did not release lock");

  AST_FORCED_PIN: assert property (@(posedge clock_i)
    disable iff (!reset_n_i)
    $rose(forced_act_q) |-> (!$past(authorised_q) && !$past(lock_o)))
    else $error("forced raised with access present");

endmodule : dao_door_ctrl

// file: src/dao_pkg.sv
/*
  package for the door alarm output and option block: timing counts,
  option bit positions, reset values and the carrier structs.
  assumes a 10 MHz system clock and one synchronous active-low reset.
*/
package dao_pkg;

  // ==========================================================
  // timing
  // ==========================================================
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TICK_MS = 100;          // pulse step in ms
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam logic [3:0] TICKS_PER_SEC = 4'hA;    // 100 ms steps a second
  localparam logic [9:0] TICKS_PER_MIN = 10'h258; // 600 steps a minute

  // ==========================================================
  // option bit positions, bit n-1 holds option n
  // ==========================================================
  localparam int OPT_REVAL = 0;
  localparam int OPT_NO_SCHED_EVT = 1;
  localparam int OPT_PRE_EVT = 2;
  localparam int OPT_LEFT_EVT = 3;
  localparam int OPT_RELOCK = 4;
  localparam int OPT_REX_UNLOCK = 5;
  localparam int OPT_REN_UNLOCK = 6;
  localparam int OPT_LATE_OPEN = 7;

  // ==========================================================
  // reset values
  // ==========================================================
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ==========================================================
  // carriers
  // ==========================================================
  // on and off phase times in 100 ms steps
  typedef struct packed {
    logic [7:0] on_time;
    logic [7:0] off_time;
  } dao_pulse_cfg_t;

  // one-cycle event strobes toward the log
  typedef struct packed {
    logic opened;
    logic closed;
    logic pre_alarm;
    logic left_open;
    logic forced;
  } dao_events_t;

endpackage : dao_pkg

// file: testbench/dao_door_ctrl_tb.sv
/*
  self-checking bench for the door alarm output and option block.
  assumes the door model file and the design package are compiled first.
*/
`timescale 1ns/100ps
module dao_door_ctrl_tb;
  // ==========================================================
  // stimulus and observation
  // ==========================================================
  localparam int M_NEVER = 0;   // never high in the window
  localparam int M_EVER = 1;    // high at least once
  localparam int M_ALWAYS = 2;  // high on every sample
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic open_cmd = 1'b0;
  logic exit_cmd = 1'b0;
  logic enter_cmd = 1'b0;
  logic access = 1'b0;
  logic sched = 1'b0;
  logic minute = 1'b0;
  logic inside_dis = 1'b0;
  logic outside_dis = 1'b0;
  logic [7:0] options = 8'h00;
  logic [7:0] pre_sec = 8'h00;
  logic [7:0] max_sec = 8'h00;
  logic [7:0] unlock_sec = 8'h05;
  dao_pkg::dao_pulse_cfg_t pre_cfg = '0;
  dao_pkg::dao_pulse_cfg_t left_cfg = '0;
  dao_pkg::dao_pulse_cfg_t forced_cfg = '0;
  logic door_open, request_to_exit, ren, pre, left, forced, lock;
  dao_pkg::dao_events_t events;
  logic [8:0] cur, any_v, all_v;  // observed outputs, window summaries
  int mismatches = 0;
  int samples_checked = 0;
  // 0 forced 1 left 2 pre 3 lock 4 opened 5 closed 6 left ev 7 forced ev
  assign cur = {events.pre_alarm, events.forced, events.left_open,
    events.closed, events.opened, lock, pre, left, forced};
  always #50 clock_i = ~clock_i;
  dao_door_model i_door (
    .open_cmd_i(open_cmd),
    .exit_cmd_i(exit_cmd),
    .enter_cmd_i(enter_cmd),
    .door_open_o(door_open),
    .request_to_exit_o(request_to_exit),
    .request_to_enter_o(ren)
  );
  dao_door_ctrl i_dut (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .door_open_i(door_open),
    .request_to_exit_i(request_to_exit),
    .request_to_enter_i(ren),
    .access_granted_i(access),
    .sched_valid_i(sched),
    .minute_tick_i(minute),
    .inside_disarmed_i(inside_dis),
    .outside_disarmed_i(outside_dis),
    .options_i(options),
    .pre_alarm_sec_i(pre_sec),
    .max_open_sec_i(max_sec),
    .unlock_sec_i(unlock_sec),
    .pre_cfg_i(pre_cfg),
    .left_cfg_i(left_cfg),
    .forced_cfg_i(forced_cfg),
    .pre_alarm_o(pre),
    .left_open_o(left),
    .forced_o(forced),
    .lock_o(lock),
    .events_o(events)
  );
  // ==========================================================
  // shared tasks
  // ==========================================================
  // every scenario starts from reset so old state cannot leak in
  task automatic reset_dut();
    @(posedge clock_i);
    reset_n_i <= 1'b0;
    open_cmd <= 1'b0;
    exit_cmd <= 1'b0;
    enter_cmd <= 1'b0;
    sched <= 1'b0;
    inside_dis <= 1'b0;
    outside_dis <= 1'b0;
    options <= 8'h00;
    forced_cfg <= '0;
    left_cfg <= '0;
    unlock_sec <= 8'h05;
    repeat (8) @(posedge clock_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge clock_i);
  endtask : reset_dut
  // sample settled outputs for n cycles
  task automatic run(input int n);
    any_v = '0;
    all_v = '1;
    repeat (n) begin
      @(negedge clock_i);
      any_v = any_v | cur;
      all_v = all_v & cur;
    end
    // hand back on a rising edge so the next drive lands on it
    @(posedge clock_i);
  endtask : run
  task automatic check_sig(input int sel, input int mode);
    logic got;
    logic want;
    got = (mode == M_ALWAYS) ? all_v[sel] : any_v[sel];
    want = (mode != M_NEVER);
    samples_checked++;
    if (got !== want) begin
      mismatches++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, want);
    end
  endtask : check_sig
  // held for several cycles, long enough to clear the pin sync
  task automatic press(input int which);
    @(posedge clock_i);
    exit_cmd <= (which == 0);
    enter_cmd <= (which != 0);
    repeat (5) @(posedge clock_i);
    exit_cmd <= 1'b0;
    enter_cmd <= 1'b0;
  endtask : press
  task automatic door(input logic open);
    @(posedge clock_i);
    open_cmd <= open;
  endtask : door
  // ==========================================================
  // scenarios
  // ==========================================================
  // unattended opening, zero open limit, steady outputs
  task automatic t_forced();
    reset_dut();
    options <= 8'h0C;
    door(1'b1);
    run(20);
    check_sig(7, M_EVER);   // forced event
    check_sig(0, M_EVER);   // forced output
    check_sig(4, M_EVER);   // opened event
    check_sig(1, M_EVER);   // left open
    check_sig(6, M_EVER);   // left event
    run(2000);
    check_sig(0, M_ALWAYS); // steady when times zero
    check_sig(2, M_NEVER);  // zero disables
    check_sig(8, M_NEVER);  // no pre-alarm event
    door(1'b0);
    run(20);
    check_sig(5, M_EVER);   // closed event
    run(10);
    check_sig(1, M_NEVER);  // cleared on close
  endtask : t_forced
  // one zero time stays steady, pulsing starts in the on-phase
  task automatic t_pulse();
    reset_dut();
    forced_cfg.on_time <= 8'h01;
    left_cfg.on_time <= 8'h01;
    left_cfg.off_time <= 8'h01;
    door(1'b1);
    run(20);
    check_sig(6, M_NEVER);  // no event with option clear
    run(2000);
    check_sig(0, M_ALWAYS); // one zero time
    check_sig(1, M_ALWAYS); // on-phase first
  endtask : t_pulse
  // exit and enter requests, then relock on close
  task automatic t_requests();
    for (int i = 0; i < 2; i++) begin
      reset_dut();
      press(i);
      run(30);
      check_sig(3, M_NEVER); // option clear
      options <= (i == 0) ? 8'h30 : 8'h50;
      press(i);
      run(30);
      check_sig(3, M_EVER);  // option set
      door(1'b1);
      run(30);
      check_sig(0, M_NEVER); // request seen
      check_sig(3, M_ALWAYS); // held while open
      door(1'b0);
      run(10);
      run(20);
      check_sig(3, M_NEVER); // relock on close
    end
  endtask : t_requests
  // plain schedule, quiet opening, then late open
  task automatic t_schedule();
    reset_dut();
    options <= 8'h02;
    sched <= 1'b1;
    run(20);
    check_sig(3, M_EVER);   // normal unlock
    door(1'b1);
    run(20);
    check_sig(4, M_NEVER);  // no opened event
    door(1'b0);
    sched <= 1'b0;
    run(20);
    run(10);
    check_sig(3, M_NEVER);  // end time locks
    options <= 8'h80;
    sched <= 1'b1;
    unlock_sec <= 8'h00; // access alone must not release the lock
    run(30);
    check_sig(3, M_NEVER);  // withheld
    access <= 1'b1;
    @(posedge clock_i);
    access <= 1'b0;
    run(20);
    check_sig(3, M_EVER);   // after first access
  endtask : t_schedule
  // area follow with and without revalidation, then minute revalidation
  task automatic t_minute();
    reset_dut();
    options <= 8'h01;
    inside_dis <= 1'b1;
    outside_dis <= 1'b1;
    run(30);
    check_sig(3, M_NEVER);  // area follow off
    options <= 8'h00;
    run(5);
    run(20);
    check_sig(3, M_ALWAYS); // area follow without revalidation
    inside_dis <= 1'b0;
    outside_dis <= 1'b0;
    for (int i = 1; i >= 0; i--) begin
      // schedule unlocks with late open clear
      options <= {7'h00, i[0]};
      sched <= 1'b1;
      run(10);
      // late open now set: only a re-evaluation withdraws the unlock
      options <= {7'h40, i[0]};
      minute <= 1'b1;
      @(posedge clock_i);
      minute <= 1'b0;
      run(5);
      run(10);
      check_sig(3, (i == 1) ? M_NEVER : M_ALWAYS); // per minute
      sched <= 1'b0;
      run(5);
    end
  endtask : t_minute
  // ==========================================================
  // verdict, main sequence and watchdog
  // ==========================================================
  task automatic end_of_test();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test
  initial begin
    t_forced();
    t_pulse();
    t_requests();
    t_schedule();
    t_minute();
    end_of_test();
  end
  // about 5000 cycles needed, allow ten times that
  initial begin
    #5_000_000;
    mismatches++;
    end_of_test();
  end
endmodule : dao_door_ctrl_tb

// file: testbench/dao_door_model.sv
/*
  behavioural door for the door controller bench: contact and buttons.
  assumes the bench commands it; pins move a little after each command.
*/
`timescale 1ns/100ps
module dao_door_model (
  input wire logic open_cmd_i,   // bench wants the door open
  input wire logic exit_cmd_i,   // bench presses the exit button
  input wire logic enter_cmd_i,  // bench presses the enter button
  output logic door_open_o,      // contact, high = open
  output logic request_to_exit_o,
  output logic request_to_enter_o
);
  // ==========================================================
  // pins
  // ==========================================================
  // skewed off the clock, real contacts are asynchronous
  always @(open_cmd_i) door_open_o <= #13 open_cmd_i;
  always @(exit_cmd_i) request_to_exit_o <= #17 exit_cmd_i;
  always @(enter_cmd_i) request_to_enter_o <= #19 enter_cmd_i;
  // closed door, buttons released at power up
  initial begin
    door_open_o = 1'b0;
    request_to_exit_o = 1'b0;
    request_to_enter_o = 1'b0;
  end
endmodule : dao_door_model
